/* dv/nfbrc_props.sv */
// checker on the flash pin bundle between host and device ends
`timescale 1ns/1ps
module nfbrc_props (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic rst_b,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic address_valid_low,
    input wire logic dq_h_oe,
    input wire logic dq_d_oe,
    input wire logic wait_oe
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_read_start;
        $fell(oe_b) && !ce_b && we_b && rst_b;
    endsequence
    sequence s_reset_hold;
        (!rst_b) [*4];
    endsequence

    // ----------------------------------------
    // device side
    // ----------------------------------------
    // four cycles cover the two-flop sync plus the output register
    a_reset_floats: assert property (
        s_reset_hold |-> !dq_d_oe && !wait_oe)
        else $error("device drives while flash reset held");
    a_oe_floats: assert property (
        oe_b [*4] |-> !dq_d_oe && !wait_oe)
        else $error("device drives with output enable high");
    a_standby_floats: assert property (
        ce_b [*4] |-> !dq_d_oe)
        else $error("device drives while deselected");
    a_read_drives: assert property (
        s_read_start |-> ##[1:5] dq_d_oe)
        else $error("device never drove read data");

    // ----------------------------------------
    // host side
    // ----------------------------------------
    a_reset_pulse: assert property (
        $fell(rst_b) |-> s_reset_hold)
        else $error("flash reset pulse shorter than four cycles");
    a_wake_wait: assert property (
        $rose(rst_b) |-> ce_b [*6])
        else $error("host selected flash before wake-up wait");
    a_addr_phase: assert property (
        !address_valid_low |-> we_b && rst_b && !ce_b)
        else $error("bad control levels during address phase");
    a_write_data: assert property (
        !we_b |-> dq_h_oe && oe_b)
        else $error("host not driving data during write strobe");
endmodule

/* dv/nfbrc_tb.sv */
// self-checking bench for host and device ends joined by the pin bundle
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    miscompares++; $display("wrong value at %0t: got %h expected %h", \
    $time, got, exp); end end
module nfbrc_tb;
    import nfbrc_pkg::*;
    localparam logic [ADDR_W-1:0] ADDR = 24'h3A0003;
    logic sys_clk, rst_b, reset_req;
    logic req_valid, req_write, req_ready, rsp_valid;
    logic busy, sync_mode, aborted;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data, rsp_data, got;
    logic [7:0] block;
    int miscompares, comparisons, ab_cyc;

    nfbrc_bus_if intf();
    nfbrc_host nfbrc_host_i (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .bus(intf),
        .req_valid_i(req_valid), .req_write_i(req_write),
        .req_addr_i(req_addr), .req_data_i(req_data),
        .reset_req_i(reset_req), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
    // short abort count keeps the run brief; one system reset feeds both
    nfbrc_device #(.ABORT_CYC(20)) nfbrc_device_i (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .bus(intf), .busy_o(busy),
        .sync_mode_o(sync_mode), .abort_o(aborted), .block_o(block));
    nfbrc_props nfbrc_props_i (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .rst_b(intf.rst_b),
        .ce_b(intf.ce_b), .oe_b(intf.oe_b), .we_b(intf.we_b),
        .address_valid_low(intf.address_valid_low),
        .dq_h_oe(intf.dq_h_oe), .dq_d_oe(intf.dq_d_oe),
        .wait_oe(intf.wait_oe));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    // valid rises only once ready is settled, so the next edge takes it
    task automatic req(input logic w, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 600) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        if (req_ready !== 1'b1) miscompares++;
        req_write = w;
        req_addr = ADDR;
        req_data = d;
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1 req_valid = 1'b0;
    endtask
    // room for the pin syncs and the device queue to act on the word
    task automatic wr(input logic [DATA_W-1:0] d);
        req(1'b1, d);
        repeat (14) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(output logic [DATA_W-1:0] d);
        int n;
        req(1'b0, '0);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        if (rsp_valid !== 1'b1) miscompares++;
        d = rsp_data;
    endtask
    task automatic wait_busy();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < OP_CYC * 4) begin
            n++;
            @(posedge sys_clk);
        end
        #1;
    endtask
    task automatic freset();
        int n;
        reset_req = 1'b1;
        ab_cyc = 0;
        n = 0;
        @(posedge sys_clk);
        while (intf.rst_b !== 1'b0 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        #1 reset_req = 1'b0;
        while ((req_ready !== 1'b1 || aborted !== 1'b0) && n < 300) begin
            @(posedge sys_clk);
            n++;
            if (aborted === 1'b1) ab_cyc++;
        end
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #500000;
        miscompares++;
        conclude();
    end
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_data = '0;
        reset_req = 1'b0;
        miscompares = 0;
        comparisons = 0;
        ab_cyc = 0;
        repeat (4) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK(req_ready, 1'b1)
        wr(DATA_W'(CMD_READ_STATUS));
        rd(got);
        `CHK(got[7:0], STATUS_RESET)
        `CHK(sync_mode, 1'b0)
        wr(DATA_W'(CMD_ERASE));
        wr(DATA_W'(CMD_CONFIRM));
        wait_busy();
        `CHK(block, ADDR[BLK_HI:BLK_LO])
        wr(DATA_W'(CMD_PROGRAM));
        wr(16'h5A5A);
        // host is idle and flash deselected, the program must still run
        `CHK(busy, 1'b1)
        // a write landing mid-program waits in the device queue
        wr(DATA_W'(CMD_SYNC_ON));
        `CHK(sync_mode, 1'b0)
        wait_busy();
        `CHK(busy, 1'b0)
        wr(DATA_W'(CMD_READ_ARRAY));
        `CHK(sync_mode, 1'b1)
        rd(got);
        `CHK(got, 16'h5A5A)
        freset();
        `CHK(ab_cyc, 0)
        `CHK(sync_mode, 1'b0)
        wr(DATA_W'(CMD_READ_STATUS));
        rd(got);
        `CHK(got[7:0], STATUS_RESET)
        wr(DATA_W'(CMD_PROGRAM));
        wr(16'h0000);
        freset();
        `CHK(ab_cyc > 0 && ab_cyc <= 20, 1'b1)
        `CHK(busy, 1'b0)
        conclude();
    end
endmodule

/* logic/nfbrc_bus_if.sv */
// flash pin bundle joining host and device ends
`timescale 1ns/1ps
interface nfbrc_bus_if;
    import nfbrc_pkg::*;
    logic rst_b;
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic address_valid_low;
    logic fclk;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_h_o;
    logic dq_h_oe;
    logic [DATA_W-1:0] dq_d_o;
    logic dq_d_oe;
    logic wait_o;
    logic wait_oe;
    wire [DATA_W-1:0] dq = dq_h_oe ? dq_h_o : (dq_d_oe ? dq_d_o : '0);
    modport host (output rst_b, ce_b, oe_b, we_b, address_valid_low, fclk,
        addr, dq_h_o, dq_h_oe, input dq, wait_o, wait_oe);
    modport device (input rst_b, ce_b, oe_b, we_b, address_valid_low, fclk,
        addr, dq, output dq_d_o, dq_d_oe, wait_o, wait_oe);
endinterface

/* logic/nfbrc_device.sv */
// flash device end: bus decode, address latch, reset and abort behaviour
`timescale 1ns/1ps
module nfbrc_device
    import nfbrc_pkg::*;
#(
    parameter int ABORT_CYC = RESET_ABORT_CYC,
    parameter int MEM_WORDS = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    nfbrc_bus_if.device bus,
    output logic busy_o,
    output logic sync_mode_o,
    output logic abort_o,
    output logic [nfbrc_pkg::BLK_HI-nfbrc_pkg::BLK_LO:0] block_o
);
    import nfbrc_pkg::*;
    localparam int MW = $clog2(MEM_WORDS);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_q_r;
    logic [ADDR_W-1:0] a_s1_r;
    logic [ADDR_W-1:0] a_s2_r;
    logic [DATA_W-1:0] d_s1_r;
    logic [DATA_W-1:0] d_s2_r;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_r <= 6'h3F;
            pin_s2_r <= 6'h3F;
            pin_q_r <= 6'h3F;
            a_s1_r <= '0;
            a_s2_r <= '0;
            d_s1_r <= '0;
            d_s2_r <= '0;
        end else begin
            pin_s1_r <= {bus.rst_b, bus.ce_b, bus.oe_b, bus.we_b,
                bus.address_valid_low, bus.fclk};
            pin_s2_r <= pin_s1_r;
            pin_q_r <= pin_s2_r;
            a_s1_r <= bus.addr;
            a_s2_r <= a_s1_r;
            d_s1_r <= bus.dq;
            d_s2_r <= d_s1_r;
        end
    end
    logic frst_b;
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic adv_b;
    logic clk_rise;
    logic wr_end;
    assign frst_b = pin_s2_r[5];
    // reset masks every other control pin except fclk
    assign ce_b = pin_s2_r[4] | ~frst_b;
    assign oe_b = pin_s2_r[3] | ~frst_b;
    assign we_b = pin_s2_r[2] | ~frst_b;
    assign adv_b = pin_s2_r[1] | ~frst_b;
    assign clk_rise = pin_s2_r[0] & ~pin_q_r[0];
    // write ends on whichever strobe rises first
    assign wr_end = (~pin_q_r[4] & ~pin_q_r[2] & pin_q_r[5])
        & (ce_b | we_b);

    // ----------------------------------------------------------------
    // address latch
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addr_r;
    logic sync_r;
    logic sync_held_r;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_r <= '0;
            sync_held_r <= 1'b0;
        end else if (!frst_b) begin
            sync_held_r <= 1'b0;
        end else if (!sync_r) begin
            if (!adv_b) begin
                addr_r <= a_s2_r;
            end
        end else if (!adv_b && !sync_held_r && !ce_b) begin
            // clock edges are ignored while a write is in progress
            if (clk_rise && we_b) begin
                addr_r <= a_s2_r;
                sync_held_r <= 1'b1;
            end else begin
                addr_r <= a_s2_r;
            end
        end else if (adv_b) begin
            sync_held_r <= 1'b0;
        end
    end
    assign block_o = addr_r[BLK_HI:BLK_LO];

    // ----------------------------------------------------------------
    // command entry interface and program/erase engine
    // ----------------------------------------------------------------
    logic [7:0] cmd_r;
    logic [7:0] status_r;
    logic read_status_r;
    logic busy_r;
    logic [CNT_W-1:0] op_cnt_r;
    logic [MW-1:0] op_idx_r;
    logic [DATA_W-1:0] op_data_r;
    logic op_erase_r;
    logic [DATA_W-1:0] mem_r [MEM_WORDS];
    logic [CNT_W-1:0] abort_cnt_r;
    logic abort_r;
    logic fifo_valid;
    logic fifo_ready;
    logic [ADDR_W+DATA_W-1:0] fifo_data;
    logic [7:0] wcmd;
    assign wcmd = fifo_data[7:0];
    // latched write words queue ahead of the command decoder
    nfbrc_fifo #(.WIDTH(ADDR_W+DATA_W), .DEPTH(8)) u_wq (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i & frst_b),
        .in_valid_i(wr_end),
        .in_ready_o(),
        .in_data_i({addr_r, d_s2_r}),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready),
        .out_data_o(fifo_data)
    );
    // decoder stalls while the engine is busy
    assign fifo_ready = !busy_r && !abort_r;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_r <= CMD_READ_ARRAY;
            status_r <= STATUS_RESET;
            read_status_r <= 1'b0;
            sync_r <= 1'b0;
            busy_r <= 1'b0;
            op_cnt_r <= '0;
            op_idx_r <= '0;
            op_data_r <= '0;
            op_erase_r <= 1'b0;
        end else if (!frst_b) begin
            // reset shuts down the work in progress
            cmd_r <= CMD_READ_ARRAY;
            status_r <= STATUS_RESET;
            read_status_r <= 1'b0;
            sync_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (busy_r) begin
            // runs on whether or not the chip is selected
            if (op_cnt_r == '0) begin
                busy_r <= 1'b0;
                status_r <= STATUS_RESET;
            end else begin
                op_cnt_r <= op_cnt_r - 1'b1;
            end
        end else if (fifo_valid && fifo_ready) begin
            // a word held back by an abort must not be decoded twice
            cmd_r <= wcmd;
            read_status_r <= 1'b0;
            if (cmd_r == CMD_PROGRAM) begin
                busy_r <= 1'b1;
                op_erase_r <= 1'b0;
                op_idx_r <= fifo_data[DATA_W +: MW];
                op_data_r <= fifo_data[DATA_W-1:0];
                op_cnt_r <= CNT_W'(OP_CYC);
                status_r <= status_r & STATUS_BUSY_CLR;
                read_status_r <= 1'b1;
                cmd_r <= CMD_READ_STATUS;
            end else if (cmd_r == CMD_ERASE && wcmd == CMD_CONFIRM) begin
                busy_r <= 1'b1;
                op_erase_r <= 1'b1;
                op_cnt_r <= CNT_W'(OP_CYC);
                status_r <= status_r & STATUS_BUSY_CLR;
                read_status_r <= 1'b1;
                cmd_r <= CMD_READ_STATUS;
            end else if (wcmd == CMD_READ_STATUS) begin
                read_status_r <= 1'b1;
            end else if (wcmd == CMD_SYNC_ON) begin
                sync_r <= 1'b1;
            end else if (wcmd == CMD_SYNC_OFF) begin
                sync_r <= 1'b0;
            end
        end
    end

    // a cut program ANDs its target word with the inverted data; a cut erase leaves memory unchanged
    always_ff @(posedge sys_clk_i) begin
        if (busy_r && frst_b && op_cnt_r == '0) begin
            if (op_erase_r) begin
                for (int i = 0; i < MEM_WORDS; i++) begin
                    mem_r[i] <= '1;
                end
            end else begin
                mem_r[op_idx_r] <= mem_r[op_idx_r] & op_data_r;
            end
        end else if (busy_r && !frst_b && !op_erase_r) begin
            mem_r[op_idx_r] <= mem_r[op_idx_r] & ~op_data_r;
        end
    end

    // abort counter: holds abort, stalling the decoder, until internal reset finishes
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            abort_r <= 1'b0;
            abort_cnt_r <= '0;
        end else if (!frst_b && busy_r) begin
            abort_r <= 1'b1;
            abort_cnt_r <= CNT_W'(ABORT_CYC - 1);
        end else if (abort_r) begin
            if (abort_cnt_r == '0) begin
                abort_r <= 1'b0;
            end else begin
                abort_cnt_r <= abort_cnt_r - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // output drivers
    // ----------------------------------------------------------------
    logic drive;
    // idle reset completes in the same cycle it is seen
    assign drive = frst_b && !ce_b && !oe_b && we_b;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus.dq_d_o <= '0;
            bus.dq_d_oe <= 1'b0;
            bus.wait_o <= 1'b0;
            bus.wait_oe <= 1'b0;
        end else begin
            bus.dq_d_oe <= drive;
            bus.wait_oe <= drive;
            bus.wait_o <= !sync_r;
            if (read_status_r) begin
                bus.dq_d_o <= {8'h00, status_r};
            end else begin
                bus.dq_d_o <= mem_r[addr_r[MW-1:0]];
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
            sync_mode_o <= 1'b0;
            abort_o <= 1'b0;
        end else begin
            busy_o <= busy_r;
            sync_mode_o <= sync_r;
            abort_o <= abort_r;
        end
    end
endmodule

/* logic/nfbrc_fifo.sv */
// parameterised flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module nfbrc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

/* logic/nfbrc_host.sv */
// host end: drives flash pins for reads, writes and timed resets
`timescale 1ns/1ps
module nfbrc_host
    import nfbrc_pkg::*;
#(
    parameter int PULSE_CYC = RESET_PULSE_MIN_CYC,
    parameter int WAKE_CY = WAKE_CYC,
    parameter int STROBE_CYC = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    nfbrc_bus_if.host bus,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [nfbrc_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [nfbrc_pkg::DATA_W-1:0] req_data_i,
    input wire logic reset_req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [nfbrc_pkg::DATA_W-1:0] rsp_data_o
);
    import nfbrc_pkg::*;
    typedef enum logic [2:0] {
        H_RESET, H_WAKE, H_IDLE, H_ADDR, H_STROBE, H_DONE
    } nfbrc_hst_t;
    nfbrc_hst_t st_r;
    logic [CNT_W-1:0] cnt_r;
    logic wr_r;
    logic [DATA_W-1:0] dq_s1_r;
    logic [DATA_W-1:0] dq_s2_r;

    // ----------------------------------------------------------------
    // data input synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end else begin
            dq_s1_r <= bus.dq;
            dq_s2_r <= dq_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= H_RESET;
            cnt_r <= CNT_W'(PULSE_CYC);
            wr_r <= 1'b0;
            bus.rst_b <= 1'b0;
            bus.ce_b <= 1'b1;
            bus.oe_b <= 1'b1;
            bus.we_b <= 1'b1;
            bus.address_valid_low <= 1'b1;
            bus.fclk <= 1'b0;
            bus.addr <= '0;
            bus.dq_h_o <= '0;
            bus.dq_h_oe <= 1'b0;
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= '0;
        end else begin
            rsp_valid_o <= 1'b0;
            unique case (st_r)
                H_RESET: begin
                    if (cnt_r == '0) begin
                        bus.rst_b <= 1'b1;
                        cnt_r <= CNT_W'(WAKE_CY);
                        st_r <= H_WAKE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                H_WAKE: begin
                    if (cnt_r == '0) begin
                        req_ready_o <= 1'b1;
                        st_r <= H_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                H_IDLE: begin
                    if (reset_req_i) begin
                        req_ready_o <= 1'b0;
                        bus.rst_b <= 1'b0;
                        cnt_r <= CNT_W'(PULSE_CYC);
                        st_r <= H_RESET;
                    end else if (req_valid_i) begin
                        req_ready_o <= 1'b0;
                        wr_r <= req_write_i;
                        bus.addr <= req_addr_i;
                        bus.dq_h_o <= req_data_i;
                        bus.ce_b <= 1'b0;
                        bus.address_valid_low <= 1'b0;
                        cnt_r <= CNT_W'(STROBE_CYC);
                        st_r <= H_ADDR;
                    end
                end
                H_ADDR: begin
                    bus.address_valid_low <= 1'b1;
                    if (wr_r) begin
                        bus.we_b <= 1'b0;
                        bus.dq_h_oe <= 1'b1;
                    end else begin
                        bus.oe_b <= 1'b0;
                    end
                    st_r <= H_STROBE;
                end
                H_STROBE: begin
                    if (cnt_r == '0) begin
                        bus.we_b <= 1'b1;
                        bus.oe_b <= 1'b1;
                        st_r <= H_DONE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                H_DONE: begin
                    bus.ce_b <= 1'b1;
                    bus.dq_h_oe <= 1'b0;
                    // device and host syncs delay read data one cycle more
                    rsp_data_o <= dq_s2_r;
                    rsp_valid_o <= !wr_r;
                    req_ready_o <= 1'b1;
                    st_r <= H_IDLE;
                end
            endcase
        end
    end
endmodule

/* logic/nfbrc_pkg.sv */
// shared constants and types for the nor flash bus and reset control pair
package nfbrc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 24;
    localparam int BLK_HI = 23;
    localparam int BLK_LO = 16;
    localparam int CLK_PERIOD_NS = 25;
    // reset pulse minimum, ns
    localparam int RESET_PULSE_MIN_NS = 100;
    localparam int RESET_PULSE_MIN_CYC =
        (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset abort time, us (longest time, rounded down)
    localparam int RESET_ABORT_TIME_US = 25;
    localparam int RESET_ABORT_CYC =
        (RESET_ABORT_TIME_US * 1000) / CLK_PERIOD_NS;
    // wake-up wait after release, ns
    localparam int WAKE_NS = 150;
    localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OP_CYC = 64;
    localparam int CNT_W = 16;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] STATUS_BUSY_CLR = 8'h7F;
    localparam logic [7:0] STATUS_ABORT = 8'h30;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_SYNC_ON = 8'h03;
    localparam logic [7:0] CMD_SYNC_OFF = 8'h04;
    typedef enum logic [1:0] {
        NFBRC_OP_NONE, NFBRC_OP_READ, NFBRC_OP_WRITE
    } nfbrc_op_t;
endpackage
